// ===== sim/tcs_medium.sv
// medium side model: mac attempt events and transceiver signals
`timescale 1ns/1ps
module tcs_medium (
   input wire logic ref_clk,
   output logic attempt_start,
   output logic sfd_sent,
   output logic carrier_sense,
   output logic collision,
   output logic excess_coll,
   output logic fifo_empty,
   output logic tx_end,
   output logic cd_heartbeat
);
   // quiet medium until the bench asks for a frame
   initial begin
      {attempt_start, sfd_sent, carrier_sense, collision} = 4'h0;
      {excess_coll, fifo_empty, tx_end, cd_heartbeat} = 4'h0;
   end

   // all changes land at the falling edge, clear of sampling
   task automatic step();
      @(negedge ref_clk);
   endtask : step

   // one attempt: start, sync done, then d cycles of data
   task automatic attempt(input int d);
      step();
      attempt_start = 1'b1;
      carrier_sense = 1'b1;
      step();
      attempt_start = 1'b0;
      sfd_sent = 1'b1;
      step();
      sfd_sent = 1'b0;
      repeat (d) step();
   endtask : attempt

   // kinds: 0 ok, 1 collide then ok, 2 excess, 3 underrun,
   // 4 late collision then ok, 5 carrier lost then ok
   task automatic frame(input int kind, input bit hb);
      // late kind waits past the slot time before colliding
      attempt(kind == 4 ? 60 : 4);
      // carrier drops a cycle before the end, inside the frame
      if (kind == 5) begin
         carrier_sense = 1'b0;
         step();
      end
      collision = (kind == 1 || kind == 2 || kind == 4);
      excess_coll = (kind == 2);
      fifo_empty = (kind == 3);
      tx_end = (kind == 0 || kind == 5);
      step();
      {collision, excess_coll, fifo_empty, tx_end} = 4'h0;
      carrier_sense = 1'b0;
      // a rescheduled frame goes again and completes
      if (kind == 1 || kind == 4) begin
         repeat (3) step();
         attempt(4);
         tx_end = 1'b1;
         step();
         tx_end = 1'b0;
         carrier_sense = 1'b0;
      end
      repeat (5) step();
      cd_heartbeat = hb;
      repeat (10) step();
      cd_heartbeat = 1'b0;
   endtask : frame
endmodule : tcs_medium

// ===== sim/tx_config_status_bench.sv
// self-checking bench for transmit configuration and status
`timescale 1ns/1ps
module tx_config_status_bench;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cfg_wr = 1'b0;
   logic [7:0] cfg_wdata = 8'h00;
   logic tx_start = 1'b0;
   logic mcast_hit = 1'b0;
   logic [5:0] mcast_hash = 6'h00;
   logic [7:0] transmit_configuration, transmit_status;
   logic crc_append, tx_enable, retry, underrun_abort;
   logic [1:0] loopback_mode;
   logic [9:0] backoff_slots;
   logic attempt_start, sfd_sent, carrier_sense, collision;
   logic excess_coll, fifo_empty, tx_end, cd_heartbeat;
   int fail_count = 0;
   int comparisons = 0;
   int seed = 32'h2891;
   int retries = 0; // retry pulses since last note
   int aborts = 0; // abort pulses since last note
   int bo_limit = 2; // backoff must stay below this
   // expected status with pulse counts; -1 skips a count
   typedef struct {logic [7:0] st; int rt; int ab;} tcs_note_type;
   tcs_note_type notes[$];
   event look;

   // 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   // short slot time keeps late collisions cheap to reach
   tx_config_status #(.SLOT_CYCLES(13'd50)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg_wdata),
      .transmit_configuration(transmit_configuration),
      .transmit_status(transmit_status), .crc_append(crc_append),
      .loopback_mode(loopback_mode), .tx_enable(tx_enable),
      .tx_start(tx_start), .attempt_start(attempt_start),
      .sfd_sent(sfd_sent), .carrier_sense(carrier_sense),
      .collision(collision), .excess_coll(excess_coll),
      .fifo_empty(fifo_empty), .tx_end(tx_end),
      .cd_heartbeat(cd_heartbeat), .mcast_hit(mcast_hit),
      .mcast_hash(mcast_hash), .retry(retry),
      .underrun_abort(underrun_abort), .backoff_slots(backoff_slots));

   tcs_medium med (
      .ref_clk(ref_clk), .attempt_start(attempt_start),
      .sfd_sent(sfd_sent), .carrier_sense(carrier_sense),
      .collision(collision), .excess_coll(excess_coll),
      .fifo_empty(fifo_empty), .tx_end(tx_end),
      .cd_heartbeat(cd_heartbeat));

   // compare and count; four-state so unknowns fail
   task automatic check(input logic [9:0] seen, input logic [9:0] want,
         input string what);
      comparisons++;
      if (seen !== want) begin
         fail_count++;
         $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen,
            want);
      end
   endtask : check

   // verdict and end of run
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test

   // watcher: counts pulses and checks the backoff draw after retry
   always @(negedge ref_clk) begin
      if (underrun_abort === 1'b1)
         aborts++;
      if (retry === 1'b1) begin
         retries++;
         @(negedge ref_clk);
         check(10'(backoff_slots < bo_limit), 10'h1, "backoff");
      end
   end

   // retire the oldest note whenever a result is due
   always @(look) begin : retire
      tcs_note_type n;
      n = notes.pop_front();
      check(10'(transmit_status), 10'(n.st), "status");
      if (n.rt >= 0)
         check(10'(retries), 10'(n.rt), "retries");
      if (n.ab >= 0)
         check(10'(aborts), 10'(n.ab), "aborts");
      retries = 0;
      aborts = 0;
   end

   // one-cycle configuration write
   task automatic wr_cfg(input logic [7:0] d);
      @(negedge ref_clk);
      cfg_wr = 1'b1;
      cfg_wdata = d;
      @(negedge ref_clk);
      cfg_wr = 1'b0;
   endtask : wr_cfg

   // one accepted multicast frame with its hash index
   task automatic hit(input logic [5:0] h);
      @(negedge ref_clk);
      mcast_hit = 1'b1;
      mcast_hash = h;
      @(negedge ref_clk);
      mcast_hit = 1'b0;
   endtask : hit

   // start, run one frame, let the heartbeat window pass, then read
   task automatic send(input int kind, input bit hb, input tcs_note_type n);
      notes.push_back(n);
      @(negedge ref_clk);
      tx_start = 1'b1;
      @(negedge ref_clk);
      tx_start = 1'b0;
      check(10'(transmit_status), 10'h0, "clear");
      med.frame(kind, hb);
      repeat (700) @(negedge ref_clk);
      -> look;
   endtask : send

   // watchdog: about 6k cycles expected, give eight times that
   initial begin
      #500_000;
      fail_count++;
      stop_test();
   end

   // main sequence
   initial begin : main
      logic [7:0] d;
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      check(10'(transmit_configuration), 10'h0, "cfg reset");
      check(10'({crc_append, loopback_mode, tx_enable}), 10'h9, "pins");
      // data config loopback select lies off-block, taken as clear
      // every loopback code with both crc settings
      for (int m = 0; m < 8; m++) begin
         d = (8'($random(seed)) & 8'hc0) | 8'(m[2:0]);
         wr_cfg(d);
         check(10'(transmit_configuration), 10'(d & 8'h1f), "cfg");
         check(10'(loopback_mode), 10'(m[2:1]), "loopback");
         check(10'(crc_append), 10'(!m[0]), "crc");
      end
      // mid-run reset brings loopback back to normal
      @(negedge ref_clk);
      rst_n = 1'b0;
      @(negedge ref_clk);
      rst_n = 1'b1;
      check(10'(loopback_mode), 10'h0, "lb reset");
      // remote disable and enable by hash
      wr_cfg(8'h08);
      hit(6'h3e);
      check(10'(tx_enable), 10'h0, "remote off");
      hit(6'($random(seed)) & 6'h3d);
      check(10'(tx_enable), 10'h0, "other hash");
      hit(6'h3f);
      check(10'(tx_enable), 10'h1, "remote on");
      hit(6'h3e);
      wr_cfg(8'h00);
      check(10'(tx_enable), 10'h1, "auto cleared");
      hit(6'h3e);
      check(10'(tx_enable), 10'h1, "auto off");
      // frames with normal backoff
      send(0, 1'b1, '{8'h01, 0, 0});
      send(0, 1'b0, '{8'h41, 0, 0});
      send(1, 1'b1, '{8'h05, 1, 0});
      send(2, 1'b1, '{8'h0c, 0, 0});
      send(3, 1'b1, '{8'h20, 0, 1});
      send(5, 1'b1, '{8'h11, 0, 0});
      // offset widens the first draws
      wr_cfg(8'h10);
      bo_limit = 16;
      send(4, 1'b1, '{8'h85, 1, 0});
      send(1, 1'b1, '{8'h05, 1, 0});
      stop_test();
   end
endmodule : tx_config_status_bench

// ===== verilog/tcs_backoff.sv
// backoff slot draw with optional low-priority offset
`timescale 1ns/1ps
`include "tcs_cfg.svh"
module tcs_backoff (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic draw,
   input wire logic [4:0] coll_num,
   input wire logic offset_en,
   output logic [9:0] backoff_slots
);
   // all state of the generator
   tcs_pkg::tcs_bo_type s_reg;
   tcs_pkg::tcs_bo_type s_next;

   // exponent of the range for collision n
   function automatic logic [3:0] backoff_exp(input logic [4:0] n,
                                               input logic offset);
      logic [4:0] k;
      k = n;
      if (offset && n <= `TCS_COLLISION_OFFSET_ENABLE_COLLISIONS) begin
         k = n + 5'h03;
      end
      if (k > 5'(`TCS_BACKOFF_MAX_EXP)) begin
         k = 5'(`TCS_BACKOFF_MAX_EXP);
      end
      return k[3:0];
   endfunction : backoff_exp

   // free-running lfsr; a draw masks it to the range
   always_comb begin
      s_next = s_reg;
      s_next.lfsr = {s_reg.lfsr[14:0],
                     s_reg.lfsr[15] ^ s_reg.lfsr[13]
                     ^ s_reg.lfsr[12] ^ s_reg.lfsr[10]};
      if (draw) begin
         s_next.slots = s_reg.lfsr[9:0]
            & ~(10'h3ff << backoff_exp(coll_num, offset_en));
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_reg <= '{lfsr: `TCS_LFSR_SEED, slots: 10'h000};
      end else begin
         s_reg <= s_next;
      end
   end

   // held until the next draw
   assign backoff_slots = s_reg.slots;

   property p_offset_range;
      @(posedge ref_clk) disable iff (!rst_n)
      draw && offset_en && coll_num == 5'h01 |=> backoff_slots < 10'h010;
   endproperty
   a_offset_range: assert property (p_offset_range)
      else $error("offset backoff range wrong");

   property p_norm_range;
      @(posedge ref_clk) disable iff (!rst_n)
      draw && !offset_en && coll_num == 5'h01 |=> backoff_slots < 10'h002;
   endproperty
   a_norm_range: assert property (p_norm_range)
      else $error("normal backoff range wrong");

endmodule : tcs_backoff

// ===== verilog/tcs_cfg.svh
// constants for the transmit configuration and status block
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

// clock period of ref_clk, in ns
`define TCS_CLK_PERIOD_NS 10
// heartbeat window after a transmission, in ns (6.4 us)
`define TCS_HB_WINDOW_NS 6400
// longest time: rounds down to whole cycles
`define TCS_HB_CYCLES (`TCS_HB_WINDOW_NS / `TCS_CLK_PERIOD_NS)
// one slot time, in ns (51.2 us)
`define TCS_SLOT_TIME_NS 51200
// least time: rounds up to whole cycles
`define TCS_SLOT_CYCLES \
   ((`TCS_SLOT_TIME_NS + `TCS_CLK_PERIOD_NS - 1) / `TCS_CLK_PERIOD_NS)

// transmit configuration field positions
`define TCS_CFG_CRC_INHIBIT 0
`define TCS_CFG_LB_LOW 1
`define TCS_CFG_LB_HIGH 2
`define TCS_CFG_AUTO_DISABLE 3
`define TCS_CFG_COLL_OFFSET 4
// configuration reset value (loopback field powers up as 0)
`define TCS_CFG_RESET 5'h00

// transmit status field positions
`define TCS_ST_TX_OK 0
`define TCS_ST_COLLIDED 2
`define TCS_ST_ABORTED 3
`define TCS_ST_CARRIER_LOST 4
`define TCS_ST_UNDERRUN 5
`define TCS_ST_HB_FAIL 6
`define TCS_ST_LATE_COLL 7
`define TCS_ST_RESET 8'h00

// multicast hash bits that switch the transmitter off and on
`define TCS_HASH_DISABLE 6'h3e
`define TCS_HASH_ENABLE 6'h3f

// backoff: collisions that get the offset, and the exponent ceiling
`define TCS_COLLISION_OFFSET_ENABLE_COLLISIONS 5'h03
`define TCS_BACKOFF_MAX_EXP 4'ha
`define TCS_LFSR_SEED 16'hace1

`endif

// ===== verilog/tcs_heartbeat.sv
// heartbeat window checker after each completed transmission
`timescale 1ns/1ps
`include "tcs_cfg.svh"
module tcs_heartbeat (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic arm,
   input wire logic cd_heartbeat,
   output logic hb_fail
);
   // all state of the checker
   tcs_pkg::tcs_hb_type s_reg;
   tcs_pkg::tcs_hb_type s_next;

   // window runs from arm; a collision signal inside it passes
   always_comb begin
      s_next = s_reg;
      s_next.fail = 1'b0;
      if (arm) begin
         s_next.busy = 1'b1;
         s_next.cnt = 10'h000;
      end else if (s_reg.busy) begin
         if (cd_heartbeat) begin
            // heartbeat seen in time
            s_next.busy = 1'b0;
         end else if (s_reg.cnt == 10'(`TCS_HB_CYCLES - 1)) begin
            // window closed without a heartbeat
            s_next.fail = 1'b1;
            s_next.busy = 1'b0;
         end else begin
            s_next.cnt = s_reg.cnt + 10'h001;
         end
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // one-cycle failure pulse
   assign hb_fail = s_reg.fail;

   property p_hb_window;
      @(posedge ref_clk) disable iff (!rst_n)
      s_reg.busy && !arm && !cd_heartbeat
         && s_reg.cnt != 10'(`TCS_HB_CYCLES - 1) |=> !hb_fail;
   endproperty
   a_hb_window: assert property (p_hb_window)
      else $error("heartbeat failure too early");

   property p_hb_fail;
      @(posedge ref_clk) disable iff (!rst_n)
      s_reg.busy && !arm && !cd_heartbeat
         && s_reg.cnt == 10'(`TCS_HB_CYCLES - 1) |=> hb_fail;
   endproperty
   a_hb_fail: assert property (p_hb_fail)
      else $error("missing heartbeat not flagged");

endmodule : tcs_heartbeat

// ===== verilog/tcs_pkg.sv
// types of the transmit configuration and status block
package tcs_pkg;

   // transmit sequencing states
   typedef enum logic [1:0] {
      TCS_IDLE = 2'h0,
      TCS_ARMED = 2'h1,
      TCS_XMIT = 2'h2
   } tcs_state_type;

   // loopback selections
   typedef enum logic [1:0] {
      TCS_LB_NORMAL = 2'h0,
      TCS_LB_ENCODER = 2'h1,
      TCS_LB_FRONTEND = 2'h2,
      TCS_LB_COAX = 2'h3
   } tcs_loopback_type;

   // main block state
   typedef struct packed {
      logic [4:0] cfg;
      logic [7:0] status;
      logic tx_dis;
      tcs_state_type st;
      logic [4:0] coll_cnt;
      logic [12:0] slot_cnt;
      logic sfd_seen;
      logic retry;
      logic underrun_abort;
   } tcs_main_type;

   // heartbeat checker state
   typedef struct packed {
      logic busy;
      logic [9:0] cnt;
      logic fail;
   } tcs_hb_type;

   // backoff generator state
   typedef struct packed {
      logic [15:0] lfsr;
      logic [9:0] slots;
   } tcs_bo_type;

endpackage : tcs_pkg

// ===== verilog/tx_config_status.sv
// transmit configuration register, status register and sequencing
`timescale 1ns/1ps
`include "tcs_cfg.svh"
module tx_config_status #(
   // one slot time in cycles; shorten for simulation
   parameter logic [12:0] SLOT_CYCLES = 13'(`TCS_SLOT_CYCLES)
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] transmit_configuration,
   output logic [7:0] transmit_status,
   output logic crc_append,
   output logic [1:0] loopback_mode,
   output logic tx_enable,
   input wire logic tx_start,
   input wire logic attempt_start,
   input wire logic sfd_sent,
   input wire logic carrier_sense,
   input wire logic collision,
   input wire logic excess_coll,
   input wire logic fifo_empty,
   input wire logic tx_end,
   input wire logic cd_heartbeat,
   input wire logic mcast_hit,
   input wire logic [5:0] mcast_hash,
   output logic retry,
   output logic underrun_abort,
   output logic [9:0] backoff_slots
);
   // all state of the block
   tcs_pkg::tcs_main_type s_reg;
   tcs_pkg::tcs_main_type s_next;
   // status bits raised this cycle
   logic [7:0] sets;
   // collision retry request towards backoff
   logic draw_req;
   // clean end of frame, arms the heartbeat window
   logic ok_end;
   // heartbeat window expired without a collision signal
   logic hb_fail;

   // true when a multicast frame hashes to the given bit
   function automatic logic hash_is(input logic hit,
                                    input logic [5:0] hash,
                                    input logic [5:0] want);
      return hit && (hash == want);
   endfunction : hash_is

   // next-state logic
   always_comb begin
      s_next = s_reg;
      s_next.retry = 1'b0;
      s_next.underrun_abort = 1'b0;
      sets = 8'h00;
      draw_req = 1'b0;
      ok_end = 1'b0;

      // bits 7:5 are ignored; software keeps them zero
      if (cfg_wr) begin
         s_next.cfg = cfg_wdata[4:0];
      end

      if (!s_next.cfg[`TCS_CFG_AUTO_DISABLE]) begin
         s_next.tx_dis = 1'b0;
      end else if (hash_is(mcast_hit, mcast_hash, `TCS_HASH_DISABLE)) begin
         s_next.tx_dis = 1'b1;
      end else if (hash_is(mcast_hit, mcast_hash, `TCS_HASH_ENABLE)) begin
         s_next.tx_dis = 1'b0;
      end

      // transmit sequencing
      case (s_reg.st)
         tcs_pkg::TCS_IDLE: begin
            if (tx_start) begin
               s_next.st = tcs_pkg::TCS_ARMED;
               s_next.coll_cnt = 5'h00;
            end
         end
         tcs_pkg::TCS_ARMED: begin
            // waiting for the mac to begin an attempt
            if (attempt_start) begin
               s_next.st = tcs_pkg::TCS_XMIT;
               s_next.slot_cnt = 13'h0000;
               s_next.sfd_seen = 1'b0;
            end
         end
         tcs_pkg::TCS_XMIT: begin
            // slot counter saturates so late collisions stay late
            if (s_reg.slot_cnt != 13'h1fff) begin
               s_next.slot_cnt = s_reg.slot_cnt + 13'h0001;
            end
            if (sfd_sent) begin
               s_next.sfd_seen = 1'b1;
            end
            // carrier watched only once the preamble is out
            if (s_reg.sfd_seen && !carrier_sense) begin
               sets[`TCS_ST_CARRIER_LOST] = 1'b1;
            end
            if (fifo_empty) begin
               sets[`TCS_ST_UNDERRUN] = 1'b1;
               s_next.underrun_abort = 1'b1;
               s_next.st = tcs_pkg::TCS_IDLE;
            end else if (collision) begin
               sets[`TCS_ST_COLLIDED] = 1'b1;
               if (s_reg.slot_cnt >= SLOT_CYCLES) begin
                  sets[`TCS_ST_LATE_COLL] = 1'b1;
               end
               if (s_reg.coll_cnt != 5'h1f) begin
                  s_next.coll_cnt = s_reg.coll_cnt + 5'h01;
               end
               if (excess_coll) begin
                  sets[`TCS_ST_ABORTED] = 1'b1;
                  s_next.st = tcs_pkg::TCS_IDLE;
               end else begin
                  s_next.retry = 1'b1;
                  draw_req = 1'b1;
                  s_next.st = tcs_pkg::TCS_ARMED;
               end
            end else if (tx_end) begin
               sets[`TCS_ST_TX_OK] = 1'b1;
               ok_end = 1'b1;
               s_next.st = tcs_pkg::TCS_IDLE;
            end
         end
         default: begin
            s_next.st = tcs_pkg::TCS_IDLE;
         end
      endcase

      if (hb_fail) begin
         sets[`TCS_ST_HB_FAIL] = 1'b1;
      end

      // clear on new start, events win over the clear
      if (tx_start && s_reg.st == tcs_pkg::TCS_IDLE) begin
         s_next.status = 8'h00;
      end
      s_next.status = s_next.status | sets;
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_reg <= '{cfg: `TCS_CFG_RESET, status: `TCS_ST_RESET,
                    tx_dis: 1'b0, st: tcs_pkg::TCS_IDLE,
                    coll_cnt: 5'h00, slot_cnt: 13'h0000,
                    sfd_seen: 1'b0, retry: 1'b0,
                    underrun_abort: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // heartbeat window after each good frame
   tcs_heartbeat u_heartbeat (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .arm(ok_end),
      .cd_heartbeat(cd_heartbeat),
      .hb_fail(hb_fail)
   );

   // backoff draw on each rescheduled collision
   tcs_backoff u_backoff (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .draw(draw_req),
      .coll_num(s_next.coll_cnt),
      .offset_en(s_reg.cfg[`TCS_CFG_COLL_OFFSET]),
      .backoff_slots(backoff_slots)
   );

   // register reads; reserved bits read as zero
   assign transmit_configuration = {3'h0, s_reg.cfg};
   // reserved status bit 1 is never set
   assign transmit_status = s_reg.status;
   assign crc_append = !s_reg.cfg[`TCS_CFG_CRC_INHIBIT];
   assign loopback_mode = {s_reg.cfg[`TCS_CFG_LB_HIGH],
                           s_reg.cfg[`TCS_CFG_LB_LOW]};
   assign tx_enable = !s_reg.tx_dis;
   assign retry = s_reg.retry;
   assign underrun_abort = s_reg.underrun_abort;

   property p_crc;
      @(posedge ref_clk) disable iff (!rst_n)
      cfg_wr |=> crc_append == !$past(cfg_wdata[0]);
   endproperty
   a_crc: assert property (p_crc)
      else $error("crc append does not follow write");

   property p_loopback;
      @(posedge ref_clk) disable iff (!rst_n)
      cfg_wr |=> loopback_mode == $past(cfg_wdata[2:1]);
   endproperty
   a_loopback: assert property (p_loopback)
      else $error("loopback mode does not follow write");

   property p_lb_reset;
      @(posedge ref_clk)
      !rst_n |=> loopback_mode == 2'h0 && transmit_configuration == 8'h00;
   endproperty
   a_lb_reset: assert property (p_lb_reset)
      else $error("loopback not normal after reset");

   property p_remote_off;
      @(posedge ref_clk) disable iff (!rst_n)
      s_reg.cfg[`TCS_CFG_AUTO_DISABLE] && !cfg_wr && mcast_hit
         && mcast_hash == `TCS_HASH_DISABLE |=> !tx_enable;
   endproperty
   a_remote_off: assert property (p_remote_off)
      else $error("transmitter not disabled by hash 62");

   property p_auto_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      cfg_wr && !cfg_wdata[3] |=> tx_enable;
   endproperty
   a_auto_clear: assert property (p_auto_clear)
      else $error("transmitter still disabled after clear");

   property p_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      tx_start && s_reg.st == tcs_pkg::TCS_IDLE && !hb_fail
         |=> transmit_status == 8'h00 ##1
             transmit_status[`TCS_ST_TX_OK] == 1'b0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("status not cleared on start");

   property p_late;
      @(posedge ref_clk) disable iff (!rst_n)
      s_reg.st == tcs_pkg::TCS_XMIT && collision && !fifo_empty
         && s_reg.slot_cnt >= SLOT_CYCLES |=> transmit_status[7];
   endproperty
   a_late: assert property (p_late)
      else $error("late collision not flagged");

   property p_resched;
      @(posedge ref_clk) disable iff (!rst_n)
      s_reg.st == tcs_pkg::TCS_XMIT && collision && !fifo_empty
         && !excess_coll |=> retry && s_reg.st == tcs_pkg::TCS_ARMED;
   endproperty
   a_resched: assert property (p_resched)
      else $error("collision not rescheduled");

   property p_ok;
      @(posedge ref_clk) disable iff (!rst_n)
      transmit_status[`TCS_ST_TX_OK] |-> !transmit_status[3]
         && !transmit_status[5];
   endproperty
   a_ok: assert property (p_ok)
      else $error("ok set with abort or underrun");

   property p_underrun;
      @(posedge ref_clk) disable iff (!rst_n)
      s_reg.st == tcs_pkg::TCS_XMIT && fifo_empty
         |=> underrun_abort && transmit_status[5] ##1 !underrun_abort;
   endproperty
   a_underrun: assert property (p_underrun)
      else $error("underrun not flagged or not one pulse");

endmodule : tx_config_status
